// file: common/cpusd_map.svh
// register map, field positions, reset values and counts of the operand decode block
`ifndef CPUSD_MAP_SVH
`define CPUSD_MAP_SVH
// register word addresses
`define CPUSD_A_CTRL 4'h0
`define CPUSD_A_INDEX 4'h1
`define CPUSD_A_SP 4'h2
`define CPUSD_A_PC 4'h3
`define CPUSD_A_FLAGS 4'h4
`define CPUSD_A_FLAGUPD 4'h5
`define CPUSD_A_EA 4'h6
`define CPUSD_A_DATA 4'h7
`define CPUSD_A_STATUS 4'h8
// control register fields
`define CPUSD_C_START 0
`define CPUSD_C_MODE 4:1
`define CPUSD_C_BIT 7:5
`define CPUSD_C_CLASS 9:8
`define CPUSD_C_WIDE 10
`define CPUSD_C_STOP 11
`define CPUSD_C_KEEP 12
`define CPUSD_C_CFG 10:1
// flag update lanes: clear mask, set mask, take mask, result values
`define CPUSD_U_CLR 7:0
`define CPUSD_U_SET 15:8
`define CPUSD_U_TAKE 23:16
`define CPUSD_U_RES 31:24
// status bits
`define CPUSD_S_ERR 4
// condition flag positions and the implemented-bit mask
`define CPUSD_F_V 7
`define CPUSD_F_H 4
`define CPUSD_F_I 3
`define CPUSD_F_N 2
`define CPUSD_F_Z 1
`define CPUSD_F_C 0
`define CPUSD_CCR_MASK 8'h9f
// constants
`define CPUSD_MODE_LAST 4'hb
`define CPUSD_ENTER_BACKGROUND_OPCODE_OP 8'hff
`define CPUSD_SP_RST 16'h00ff
`define CPUSD_ZERO_PAGE 8'h00
`define CPUSD_INC 16'h0001
`define CPUSD_STRAP_WAIT 2'h2
`endif

// file: common/cpusd_pkg.sv
// types shared by the operand decode block
`default_nettype none
package cpusd_pkg;
  typedef enum logic [3:0] {
    direct_page_mode,
    full_address_mode,
    literal_operand_mode,
    literal_word_mode,
    index_plain_mode,
    index_post_increment_mode,
    index_byte_offset_mode,
    index_byte_offset_post_increment_mode,
    index_word_offset_mode,
    stack_byte_offset_mode,
    stack_word_offset_mode,
    relative_mode
  } cpusd_mode_type;
  typedef enum logic [1:0] {
    class_other,
    compare_branch_equal_op,
    memory_copy_op
  } cpusd_class_type;
  typedef enum logic [2:0] {
    cmd_none,
    cmd_halt,
    cmd_resume,
    single_step_command,
    tagged_resume_command,
    cmd_enable_debug
  } cpusd_dbg_cmd_type;
  typedef enum logic [2:0] {
    st_idle, st_opcode, st_byte1, st_byte2, st_calc, st_data_hi, st_data_lo, st_done
  } cpusd_state_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cpusd_bus_req_type;
  typedef struct packed {
    logic valid;
    cpusd_dbg_cmd_type cmd;
  } cpusd_dbg_req_type;
  typedef struct packed {
    cpusd_state_type st;
    logic [12:0] ctrl;
    logic [15:0] ix;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ptr;
    logic [15:0] ea;
    logic [15:0] data;
    logic [7:0] condition_flags_register;
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic stopped;
    logic bkg;
    logic dbg_en;
    logic trace;
    logic err;
    logic sync1;
    logic sync2;
    logic strap_done;
    logic [1:0] strap_cnt;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic osc_on;
    logic min_on;
    logic cpu_on;
    logic [31:0] rdata;
  } cpusd_regs_type;
endpackage
`default_nettype wire

// file: rtl/cpusd_core.sv
// operand fetch and address engine with stop-mode and background debug control
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpusd_map.svh"
// What this block does
// - stop halts all clocks; keep option leaves minimum clocks for periodic wake
// - debug enable set by command or strap keeps oscillator running in stop
// - halt command during stop with debug enabled restarts clocks and enters background mode
// - enter-background opcode stops user execution and enters background mode
// - background exits only by reset, resume, single step or tagged resume
// - flags: overflow 7, half carry 4, mask 3, negative 2, zero 1, carry 0
// - each flag is kept, cleared, set or taken from the result
// - a word in memory is high byte first, low byte next address
// - direct page address is a zero upper byte and the operand byte
// - full address operand gives a complete sixteen bit address
// - branch target is next instruction address plus signed byte offset
// - plain post increment allowed only for compare-branch and memory copy; byte offset post increment only for compare-branch
// - index modes add unsigned byte or word offset to index pair
// - word offsets add modulo sixteen bits
// - stack modes add byte or word offset to stack pointer
// - word offset high byte first; byte offset sits in the low field
// - bit operations pick one bit position zero to seven
// - word literal holds high and low halves in two bytes
// - word literal high byte follows opcode, low byte after it
// - post increment adds one to index pair after the operand fetch
// - full address is read from the two bytes after the opcode, high first
module cpusd_core
  import cpusd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire cpusd_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  input wire cpusd_dbg_req_type dbg_req,
  input wire logic wake_tick,
  input wire logic debug_link_pin,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic osc_enable,
  output logic min_clock_enable,
  output logic cpu_clock_enable,
  output logic background_active
);

  // state and next state
  cpusd_regs_type s_reg;
  cpusd_regs_type s_next;

  // decoded control word
  cpusd_mode_type mode;
  cpusd_mode_type wmode;
  cpusd_class_type wcls;

  // bus terms and refusals
  logic idle;
  logic wr_ctrl;
  logic start_req;
  logic bad_mode;
  logic bad_inc;

  // operand shape, results
  logic wide;
  logic post_inc;
  logic [1:0] nbytes;
  logic [15:0] ea_calc;
  logic [7:0] bit_mask;

  // operand byte count per mode
  // relative falls to the default
  function automatic logic [1:0] bytes_of(input cpusd_mode_type m);
    case (m)
      index_plain_mode, index_post_increment_mode: bytes_of = 2'h0;
      full_address_mode, literal_word_mode: bytes_of = 2'h2;
      index_word_offset_mode, stack_word_offset_mode: bytes_of = 2'h2;
      default: bytes_of = 2'h1;
    endcase
  endfunction

  // clear, then set, then take result: take has the last word
  // spare bits 6, 5 masked
  function automatic logic [7:0] flag_apply(input logic [7:0] f, input logic [31:0] w);
    logic [7:0] v;
    v = (f & ~w[`CPUSD_U_CLR]) | w[`CPUSD_U_SET];
    v = (v & ~w[`CPUSD_U_TAKE]) | (w[`CPUSD_U_RES] & w[`CPUSD_U_TAKE]);
    flag_apply = v & `CPUSD_CCR_MASK;
  endfunction

  // effective address; all sums wrap at sixteen bits by width
  // word offsets: sign does not matter
  // relative adds to ptr past the offset
  function automatic logic [15:0] ea_of(input cpusd_regs_type s, input cpusd_mode_type m);
    case (m)
      direct_page_mode: ea_of = {`CPUSD_ZERO_PAGE, s.b1};
      full_address_mode: ea_of = {s.b1, s.b2};
      index_plain_mode, index_post_increment_mode: ea_of = s.ix;
      index_byte_offset_mode: ea_of = s.ix + {8'h00, s.b1};
      index_byte_offset_post_increment_mode: ea_of = s.ix + {8'h00, s.b1};
      index_word_offset_mode: ea_of = s.ix + {s.b1, s.b2};
      stack_byte_offset_mode: ea_of = s.sp + {8'h00, s.b1};
      stack_word_offset_mode: ea_of = s.sp + {s.b1, s.b2};
      relative_mode: ea_of = s.ptr + {{8{s.b1[7]}}, s.b1};
      default: ea_of = s.ptr;
    endcase
  endfunction

  // decode of the stored and the incoming control word
  assign mode = cpusd_mode_type'(s_reg.ctrl[`CPUSD_C_MODE]);
  assign wmode = cpusd_mode_type'(bus_req.wdata[`CPUSD_C_MODE]);
  assign wcls = cpusd_class_type'(bus_req.wdata[`CPUSD_C_CLASS]);
  assign idle = (s_reg.st == st_idle);

  // operand shape
  assign wide = s_reg.ctrl[`CPUSD_C_WIDE];
  assign nbytes = bytes_of(mode);
  assign ea_calc = ea_of(s_reg, mode);

  // one-hot bit number
  assign bit_mask = 8'h01 << s_reg.ctrl[`CPUSD_C_BIT];
  assign post_inc = (mode == index_post_increment_mode) ||
                    (mode == index_byte_offset_post_increment_mode);

  // control writes only when idle
  assign wr_ctrl = bus_req.wr && (bus_req.addr == `CPUSD_A_CTRL) && idle;
  assign start_req = wr_ctrl && bus_req.wdata[`CPUSD_C_START] &&
                     !bus_req.wdata[`CPUSD_C_STOP];

  // unknown mode codes
  assign bad_mode = bus_req.wdata[`CPUSD_C_MODE] > `CPUSD_MODE_LAST;

  // post increment forms outside their instructions are refused
  assign bad_inc = ((wmode == index_post_increment_mode) &&
                    (wcls != compare_branch_equal_op) && (wcls != memory_copy_op)) ||
                   ((wmode == index_byte_offset_post_increment_mode) &&
                    (wcls != compare_branch_equal_op));

  // all next-state logic
  always_comb begin
    // hold state; pulses drop
    s_next = s_reg;
    s_next.mem_rd = 1'b0;
    s_next.rdata = 32'h0;

    // register writes; ignored while an operand fetch is in flight
    if (bus_req.wr && idle) begin
      case (bus_req.addr)
        // start, stop not stored
        `CPUSD_A_CTRL: s_next.ctrl = {bus_req.wdata[`CPUSD_C_KEEP], 1'b0,
                                      bus_req.wdata[`CPUSD_C_CFG], 1'b0};
        `CPUSD_A_INDEX: s_next.ix = bus_req.wdata[15:0];
        `CPUSD_A_SP: s_next.sp = bus_req.wdata[15:0];
        `CPUSD_A_PC: s_next.pc = bus_req.wdata[15:0];
        // spare bits forced low
        `CPUSD_A_FLAGS: s_next.condition_flags_register = bus_req.wdata[7:0] & `CPUSD_CCR_MASK;
        // keep, clear, set or take
        `CPUSD_A_FLAGUPD: s_next.condition_flags_register = flag_apply(s_reg.condition_flags_register, bus_req.wdata);
        default: ;
      endcase
    end

    // fault flag: a new fault in the clearing cycle survives
    if (bus_req.wr && (bus_req.addr == `CPUSD_A_STATUS) &&
        bus_req.wdata[`CPUSD_S_ERR]) begin
      s_next.err = 1'b0;
    end
    // refused start only sets the fault flag; the control word is still stored
    if (start_req && (bad_mode || bad_inc)) begin
      s_next.err = 1'b1;
    end

    // strap: pin low when reset releases means start in background
    // sampled on the third edge
    s_next.sync1 = debug_link_pin;
    s_next.sync2 = s_reg.sync1;
    if (!s_reg.strap_done) begin
      if (s_reg.strap_cnt == `CPUSD_STRAP_WAIT) begin
        s_next.strap_done = 1'b1;
        if (!s_reg.sync2) begin
          s_next.bkg = 1'b1;
          s_next.dbg_en = 1'b1;
        end
      end else begin
        s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      end
    end

    // periodic wake only works when minimum clocks were kept
    // else only reset or halt ends it
    if (s_reg.stopped && wake_tick && s_reg.ctrl[`CPUSD_C_KEEP]) begin
      s_next.stopped = 1'b0;
    end
    // stop is taken only between instructions and outside background
    // stop wins over start
    if (wr_ctrl && bus_req.wdata[`CPUSD_C_STOP] && !s_reg.bkg) begin
      s_next.stopped = 1'b1;
    end

    // debug commands; the link is dead in stop unless the oscillator is held
    if (dbg_req.valid && (!s_reg.stopped || s_reg.dbg_en)) begin
      case (dbg_req.cmd)
        // wakes a stopped core
        cmd_halt: begin
          s_next.stopped = 1'b0;
          s_next.bkg = 1'b1;
        end
        // both resume forms
        cmd_resume, tagged_resume_command: begin
          s_next.bkg = 1'b0;
          s_next.trace = 1'b0;
        end
        // ignored outside background
        single_step_command: begin
          if (s_reg.bkg) begin
            s_next.bkg = 1'b0;
            s_next.trace = 1'b1;
          end
        end
        // sticky until reset
        cmd_enable_debug: s_next.dbg_en = 1'b1;
        default: ;
      endcase
    end

    // operand engine; placed after the debug commands so its background entry beats a resume
    case (s_reg.st)
      // wait for start
      st_idle: begin
        if (start_req && !bad_mode && !bad_inc && !s_reg.bkg && !s_reg.stopped) begin
          s_next.mem_addr = s_reg.pc;
          s_next.mem_rd = 1'b1;
          s_next.ptr = s_reg.pc + `CPUSD_INC;
          s_next.st = st_opcode;
        end
      end
      // opcode on the bus
      st_opcode: begin
        s_next.opc = mem_rdata;
        if (mem_rdata == `CPUSD_ENTER_BACKGROUND_OPCODE_OP) begin
          // breakpoint: pc stays on the opcode so the host sees where
          s_next.bkg = 1'b1;
          s_next.trace = 1'b0;
          s_next.st = st_idle;
        end else if (nbytes == 2'h0) begin
          s_next.st = st_calc;
        end else begin
          s_next.mem_addr = s_reg.ptr;
          s_next.mem_rd = 1'b1;
          s_next.ptr = s_reg.ptr + `CPUSD_INC;
          s_next.st = st_byte1;
        end
      end
      // operand field
      st_byte1: begin
        // first byte is the high half of a word field, or the whole byte field
        s_next.b1 = mem_rdata;
        if (nbytes == 2'h2) begin
          s_next.mem_addr = s_reg.ptr;
          s_next.mem_rd = 1'b1;
          s_next.ptr = s_reg.ptr + `CPUSD_INC;
          s_next.st = st_byte2;
        end else begin
          s_next.st = st_calc;
        end
      end
      // low operand byte
      st_byte2: begin
        s_next.b2 = mem_rdata;
        s_next.st = st_calc;
      end
      // address ready
      st_calc: begin
        // pc moves past operands here
        s_next.pc = s_reg.ptr;
        s_next.ea = ea_calc;
        if (mode == literal_operand_mode) begin
          s_next.data = {8'h00, s_reg.b1};
          s_next.st = st_done;
        end else if (mode == literal_word_mode) begin
          s_next.data = {s_reg.b1, s_reg.b2};
          s_next.st = st_done;
        end else if (mode == relative_mode) begin
          s_next.st = st_done;
        end else begin
          s_next.mem_addr = ea_calc;
          s_next.mem_rd = 1'b1;
          s_next.st = st_data_hi;
        end
      end
      // first data byte
      st_data_hi: begin
        if (wide) begin
          s_next.data = {mem_rdata, 8'h00};
          s_next.mem_addr = s_reg.ea + `CPUSD_INC;
          s_next.mem_rd = 1'b1;
          s_next.st = st_data_lo;
        end else begin
          s_next.data = {8'h00, mem_rdata};
          s_next.st = st_done;
        end
      end
      // low data byte
      st_data_lo: begin
        s_next.data = {s_reg.data[15:8], mem_rdata};
        s_next.st = st_done;
      end
      // end of instruction
      st_done: begin
        if (post_inc) begin
          s_next.ix = s_reg.ix + `CPUSD_INC;
        end
        // a single step ends back in background after one instruction
        if (s_reg.trace) begin
          s_next.bkg = 1'b1;
          s_next.trace = 1'b0;
        end
        s_next.st = st_idle;
      end
      // unused codes
      default: s_next.st = st_idle;
    endcase

    // clock enables follow the next stop and debug state
    // same edge as stopped
    s_next.cpu_on = !s_next.stopped;
    s_next.osc_on = !s_next.stopped || s_next.dbg_en;
    s_next.min_on = s_next.osc_on || s_next.ctrl[`CPUSD_C_KEEP];

    // read data stand only in the cycle after the strobe
    // spare addresses read zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        `CPUSD_A_CTRL: s_next.rdata = {19'h0, s_reg.ctrl};
        `CPUSD_A_INDEX: s_next.rdata = {16'h0, s_reg.ix};
        `CPUSD_A_SP: s_next.rdata = {16'h0, s_reg.sp};
        `CPUSD_A_PC: s_next.rdata = {16'h0, s_reg.pc};
        `CPUSD_A_FLAGS: s_next.rdata = {24'h0, s_reg.condition_flags_register};
        `CPUSD_A_EA: s_next.rdata = {16'h0, s_reg.ea};
        `CPUSD_A_DATA: s_next.rdata = {16'h0, s_reg.data};
        // status word
        `CPUSD_A_STATUS: s_next.rdata = {8'h00, s_reg.opc, bit_mask, 2'h0, s_reg.trace,
                                         s_reg.err, s_reg.dbg_en, s_reg.stopped,
                                         s_reg.bkg, !idle};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // async reset loads constants only; strap is sampled later by the clock
  // pin reads idle-high at first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.sp <= `CPUSD_SP_RST;
      s_reg.sync1 <= 1'b1;
      s_reg.sync2 <= 1'b1;
      s_reg.osc_on <= 1'b1;
      s_reg.min_on <= 1'b1;
      s_reg.cpu_on <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // all outputs straight from the state register
  // no gate before a pin
  assign bus_rdata = s_reg.rdata;
  assign mem_addr = s_reg.mem_addr;
  assign mem_rd = s_reg.mem_rd;
  assign osc_enable = s_reg.osc_on;
  assign min_clock_enable = s_reg.min_on;
  assign cpu_clock_enable = s_reg.cpu_on;
  assign background_active = s_reg.bkg;

endmodule
`default_nettype wire

// file: testbench/cpu_stop_debug_and_operand_decode_tb.sv
// self-checking bench of the operand decode block
`timescale 1ns/1ps
`default_nettype none
`include "cpusd_map.svh"
module cpu_stop_debug_and_operand_decode_tb
  import cpusd_pkg::*;
;
  localparam logic [15:0] BGA = 16'h8000;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  cpusd_bus_req_type bus_req = '0;
  cpusd_dbg_req_type dbg_req = '0;
  logic wake_tick = 1'b0;
  logic debug_link_pin = 1'b1;
  logic [31:0] bus_rdata;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  logic mem_rd, osc_enable, min_clock_enable, cpu_clock_enable, background_active;
  int fails = 0;
  int n_checks = 0;
  cpusd_core dut (.clock, .rstn, .bus_req, .bus_rdata, .dbg_req, .wake_tick,
    .debug_link_pin, .mem_addr, .mem_rd, .mem_rdata, .osc_enable, .min_clock_enable,
    .cpu_clock_enable, .background_active);
  cpusd_mem_model #(.BG_ADDR(BGA)) u_mem (.clock, .rstn, .mem_addr, .mem_rd, .mem_rdata);
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus master: one-cycle strobes launched just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic cmd(input cpusd_dbg_cmd_type c);
    @(posedge clock);
    dbg_req <= '{valid: 1'b1, cmd: c};
    @(posedge clock);
    dbg_req.valid <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input logic p);
    @(posedge clock);
    rstn <= 1'b0;
    debug_link_pin <= p;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    for (int k = 0; k < 40; k++) begin
      rd(`CPUSD_A_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    chk("busy", 32'h0, 32'h1);
  endtask
  // operand bytes after the opcode, by mode code
  function automatic logic [15:0] nb(input int m);
    case (m)
      4, 5: return 16'h0;
      1, 3, 8, 10: return 16'h2;
      default: return 16'h1;
    endcase
  endfunction
  task automatic run(input int m, c, input logic w, input logic [15:0] p, ix, sp);
    logic [7:0] b1, b2;
    logic [15:0] ea, dat;
    logic [31:0] s;
    b1 = u_mem.byte_at(p + 16'h1);
    b2 = u_mem.byte_at(p + 16'h2);
    case (m)
      0: ea = {8'h00, b1};
      1: ea = {b1, b2};
      4, 5: ea = ix;
      6, 7: ea = ix + {8'h00, b1};
      8: ea = ix + {b1, b2};
      9: ea = sp + {8'h00, b1};
      10: ea = sp + {b1, b2};
      default: ea = p + 16'h2 + {{8{b1[7]}}, b1};
    endcase
    dat = w ? {u_mem.byte_at(ea), u_mem.byte_at(ea + 16'h1)} : {8'h00, u_mem.byte_at(ea)};
    if (m == 2) dat = {8'h00, b1};
    if (m == 3) dat = {b1, b2};
    wr(`CPUSD_A_INDEX, {16'h0, ix});
    wr(`CPUSD_A_SP, {16'h0, sp});
    wr(`CPUSD_A_PC, {16'h0, p});
    wr(`CPUSD_A_CTRL, {21'h0, w, c[1:0], 3'h0, m[3:0], 1'b1});
    wait_idle();
    rd(`CPUSD_A_PC, s);
    chk("pc", {16'h0, p + 16'h1 + nb(m)}, s);
    rd(`CPUSD_A_EA, s);
    if (m != 2 && m != 3) chk("ea", {16'h0, ea}, s);
    rd(`CPUSD_A_DATA, s);
    if (m != 11) chk("data", {16'h0, dat}, s);
    rd(`CPUSD_A_INDEX, s);
    chk("index", {16'h0, ix + ((m == 5 || m == 7) ? 16'h1 : 16'h0)}, s);
  endtask
  initial begin
    logic [31:0] s, u;
    logic [7:0] f, e;
    int m, bm[3], bc[3];
    cpusd_dbg_cmd_type ex[3];
    void'($urandom(93589));
    do_reset(1'b1);
    rd(`CPUSD_A_SP, s);
    chk("sp reset", 32'h00ff, s);
    // index and stack word offsets that wrap past the top
    run(8, 0, 1'b1, 16'h7ff0, 16'hff80, 16'h0);
    run(10, 0, 1'b1, 16'h1230, 16'h0, 16'hfff0);
    for (int i = 0; i < 30; i++) begin
      m = $urandom_range(11);
      run(m, (m == 5) ? 1 + $urandom_range(1) : (m == 7) ? 1 : $urandom_range(2),
        1'($urandom), 16'($urandom) & 16'h7ff0, 16'($urandom), 16'($urandom));
    end
    // post increment with the wrong class and an unknown mode are refused
    bm = '{5, 7, 12};
    bc = '{0, 2, 1};
    for (int i = 0; i < 3; i++) begin
      wr(`CPUSD_A_INDEX, 32'h1234);
      wr(`CPUSD_A_CTRL, {22'h0, bc[i][1:0], 3'h0, bm[i][3:0], 1'b1});
      rd(`CPUSD_A_STATUS, s);
      chk("error", 32'h1, {31'h0, s[`CPUSD_S_ERR]});
      rd(`CPUSD_A_INDEX, s);
      chk("index kept", 32'h1234, s);
      wr(`CPUSD_A_STATUS, 32'h10);
      rd(`CPUSD_A_STATUS, s);
      chk("error clr", 32'h0, {31'h0, s[`CPUSD_S_ERR]});
    end
    for (int i = 0; i < 8; i++) begin
      f = 8'($urandom);
      u = $urandom;
      wr(`CPUSD_A_FLAGS, {24'h0, f});
      rd(`CPUSD_A_FLAGS, s);
      chk("flags", {24'h0, f & 8'h9f}, s);
      wr(`CPUSD_A_FLAGUPD, u);
      e = (f & ~u[7:0]) | u[15:8];
      e = ((e & ~u[23:16]) | (u[31:24] & u[23:16])) & 8'h9f;
      rd(`CPUSD_A_FLAGS, s);
      chk("flag update", {24'h0, e}, s);
    end
    for (int b = 0; b < 8; b++) begin
      wr(`CPUSD_A_CTRL, 32'(b) << 5);
      rd(`CPUSD_A_STATUS, s);
      chk("bit select", 32'h1 << b, {24'h0, s[15:8]});
    end
    // breakpoint opcode, then each exit command in turn
    ex = '{cmd_resume, single_step_command, tagged_resume_command};
    for (int i = 0; i < 3; i++) begin
      wr(`CPUSD_A_PC, {16'h0, BGA});
      wr(`CPUSD_A_CTRL, 32'h9);
      repeat (6) @(posedge clock);
      #1 chk("bg enter", 32'h1, 32'(background_active));
      rd(`CPUSD_A_PC, s);
      chk("pc hold", {16'h0, BGA}, s);
      cmd(ex[i]);
      chk("bg exit", 32'h0, 32'(background_active));
      if (i == 1) begin
        run(4, 0, 1'b0, 16'h0100, 16'h0200, 16'h0300);
        chk("step back", 32'h1, 32'(background_active));
        cmd(cmd_resume);
      end
    end
    // stop with and without the kept minimum clocks
    wr(`CPUSD_A_CTRL, 32'h1800);
    repeat (3) @(posedge clock);
    #1 chk("stop keep", 32'h2, {osc_enable, min_clock_enable, cpu_clock_enable});
    @(posedge clock);
    wake_tick <= 1'b1;
    @(posedge clock);
    wake_tick <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk("wake", 32'h7, {osc_enable, min_clock_enable, cpu_clock_enable});
    wr(`CPUSD_A_CTRL, 32'h0800);
    repeat (3) @(posedge clock);
    #1 chk("stop all", 32'h0, {osc_enable, min_clock_enable, cpu_clock_enable});
    cmd(cmd_halt);
    chk("halt ignored", 32'h0, 32'(cpu_clock_enable));
    do_reset(1'b1);
    cmd(cmd_enable_debug);
    wr(`CPUSD_A_CTRL, 32'h0800);
    repeat (3) @(posedge clock);
    #1 chk("stop debug", 32'h6, {osc_enable, min_clock_enable, cpu_clock_enable});
    cmd(cmd_halt);
    chk("halt wake", 32'h3, {cpu_clock_enable, background_active});
    cmd(cmd_resume);
    // strap low at reset: background entry, and the debug enable it sets keeps the oscillator in stop
    do_reset(1'b0);
    #1 chk("strap bg", 32'h1, 32'(background_active));
    cmd(cmd_resume);
    wr(`CPUSD_A_CTRL, 32'h0800);
    repeat (3) @(posedge clock);
    #1 chk("strap osc", 32'h6, {osc_enable, min_clock_enable, cpu_clock_enable});
    close_out();
  end
  // watchdog: far beyond the roughly one thousand cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire

// file: testbench/cpusd_core_sva.sv
// port checker of the operand decode block
`timescale 1ns/1ps
`default_nettype none
`include "cpusd_map.svh"
module cpusd_core_sva
  import cpusd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire cpusd_bus_req_type bus_req,
  input wire logic [31:0] bus_rdata,
  input wire cpusd_dbg_req_type dbg_req,
  input wire logic wake_tick,
  input wire logic debug_link_pin,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic osc_enable,
  input wire logic min_clock_enable,
  input wire logic cpu_clock_enable,
  input wire logic background_active
);
  logic en_seen_reg;
  // debug enable is sticky until reset; strap entry is not tracked here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) en_seen_reg <= 1'b0;
    else if (dbg_req.valid && dbg_req.cmd == cmd_enable_debug && cpu_clock_enable)
      en_seen_reg <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // unimplemented flag bits and upper lanes read zero
  a_flag_bits: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == `CPUSD_A_FLAGS
    |-> (bus_rdata & 32'hffffff60) == 32'h0) else $error("flags read shows spare bits");
  a_bg_exit: assert property (
    $fell(background_active) |-> $past(dbg_req.valid) &&
    $past(dbg_req.cmd) inside {cmd_resume, single_step_command, tagged_resume_command})
    else $error("background left without an exit command");
  a_bg_quiet: assert property (
    $rose(background_active) && !$past(dbg_req.valid) |=> !mem_rd [*4])
    else $error("fetch continued in background");
  a_stop_cpu: assert property (
    $fell(cpu_clock_enable) |-> $past(bus_req.wr) &&
    $past(bus_req.addr) == `CPUSD_A_CTRL && $past(bus_req.wdata[`CPUSD_C_STOP]))
    else $error("core clock dropped without a stop write");
  a_min_cpu: assert property (
    $fell(min_clock_enable) |-> $fell(cpu_clock_enable)) else $error("min clocks off alone");
  a_osc_cpu: assert property (
    $fell(osc_enable) |-> $fell(cpu_clock_enable)) else $error("oscillator off alone");
  a_osc_kept: assert property (
    en_seen_reg |-> osc_enable) else $error("oscillator stopped with debug enabled");
  a_halt_wake: assert property (
    !cpu_clock_enable && osc_enable && dbg_req.valid && dbg_req.cmd == cmd_halt
    |-> ##[1:3] cpu_clock_enable && background_active) else $error("halt did not wake");
  a_word_order: assert property (
    mem_rd && $past(mem_rd) |-> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("back to back reads not ascending");
endmodule
bind cpusd_core cpusd_core_sva u_sva (.clock, .rstn, .bus_req, .bus_rdata, .dbg_req,
  .wake_tick, .debug_link_pin, .mem_addr, .mem_rd, .mem_rdata, .osc_enable,
  .min_clock_enable, .cpu_clock_enable, .background_active);
`default_nettype wire

// file: testbench/cpusd_mem_model.sv
// instruction memory answering in the cycle of each read
`timescale 1ns/1ps
`default_nettype none
module cpusd_mem_model #(
  parameter logic [15:0] BG_ADDR = 16'h8000
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] last_reg;
  // address scramble; only BG_ADDR may hold the background opcode
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    logic [7:0] v;
    v = a[7:0] ^ a[15:8] ^ 8'h5a;
    if (a == BG_ADDR) return 8'hff;
    return (v == 8'hff) ? 8'h00 : v;
  endfunction
  // the core samples while mem_rd stands; later the byte shows inverted
  // so a late sample is caught
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) last_reg <= 8'h00;
    else if (mem_rd) last_reg <= byte_at(mem_addr);
  end
  assign mem_rdata = mem_rd ? byte_at(mem_addr) : ~last_reg;
endmodule
`default_nettype wire
